// >>> clk_ctl_model.sv
// Model of the system clock controller that obeys the clock requests
`timescale 1ns/1ps
module clk_ctl_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic stop_req,
	input wire logic start_req,
	input wire logic sw_sleep,
	output logic clk_on
);
	// ****************
	// Clock gate state
	// ****************
	// Start wins over stop so a wake is never lost
	// Software may sleep the clock itself when the block does not ask
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			clk_on <= 1'b1;
		end else if (start_req) begin
			clk_on <= 1'b1;
		end else if (stop_req || sw_sleep) begin
			clk_on <= 1'b0;
		end
	end
endmodule // clk_ctl_model

// >>> pd_irq_ctrl.sv
// PD MAC interrupt gating, frame start flags and clock request logic
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
// Functional notes
// - Frame start flag sets even if type disabled
// - Five frame start flags, bits 7:5 read zero
// - Frame start flags drive their own interrupt
// - Flags set by hardware, write one clears
// - Each frame start enable gates its flag into the interrupt
// - Frame start enables gate interrupts only, flags still record
// - All enable bits reset to zero
// - Transmit enable bit map, bits 7 to 0
// - Receive enable bit map, bit 4 reserved
// - Receive fault enable map, bits 6:4 reserved
// - Clock stop enable requests stop when idle
// - Clock needed low whenever MAC idle and squelch inactive
// - Wake enable requests clock on activity
// - Squelch active always means clock needed
// - Stop and wake enables ignore wake flag
// - Power bit 0 enables wake flag, bit 2 wake, bit 3 stop, others reserved
// - Wake flag set at line activity start
// - Wake flag never sets while disabled
module pd_irq_ctrl
	import pd_irq_pkg::*;
(
	input wire logic MCLK,
	input wire logic SYS_RST,
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [15:0] ADR_I,
	input wire logic [3:0] SEL_I,
	input wire logic [31:0] DAT_I,
	output logic [31:0] DAT_O,
	output logic ACK_O,
	input wire logic [4:0] SOP_DETECT,
	input wire logic [7:0] TX_STATUS,
	input wire logic [7:0] RX_STATUS,
	input wire logic [7:0] RX_FAULT_STATUS,
	input wire logic MAC_IDLE,
	input wire logic SQUELCH_ACTIVE,
	input wire logic RX_LINE,
	output logic TX_IRQ,
	output logic RX_IRQ,
	output logic RX_FAULT_IRQ,
	output logic PM_IRQ,
	output logic SOP_IRQ,
	output logic CLK_STOP_REQ,
	output logic CLK_START_REQ,
	output logic CLK_NEEDED
);

	// ********************************
	// Decode helper
	// ********************************

	// Word aligned match of a register index
	function automatic logic hit(input logic [15:0] adr, input logic [13:0] idx);
		hit = (adr[15:2] == idx) && (adr[1:0] == 2'h0);
	endfunction

	// ********************************
	// Declarations
	// ********************************

	logic ack_q; // Bus answer, one cycle
	logic [31:0] rdat_q; // Read data holder
	logic [7:0] rdat_d; // Read data next value
	logic req; // New request this cycle
	logic wr; // Write with low lane selected
	logic [4:0] sop_q; // Frame start type flags
	logic [7:0] tx_en_q; // Transmit enable mask
	logic [7:0] rx_en_q; // Receive enable mask
	logic [7:0] rxf_en_q; // Receive fault enable mask
	logic [7:0] pm_en_q; // Power event enable/control
	logic [4:0] sop_en_q; // Frame start type mask
	logic act_q; // Activity wake flag
	logic rx_s1_q; // Line sync, first stage
	logic rx_s2_q; // Line sync, second stage
	logic rx_s3_q; // Delayed copy for edge find
	logic rx_rise; // Start of line activity
	logic wake_q; // Wake request pending
	logic tx_irq_q; // Registered group outputs
	logic rx_irq_q;
	logic rxf_irq_q;
	logic pm_irq_q;
	logic sop_irq_q;
	logic stop_q; // Clock stop request
	logic need_q; // Clock needed indication

	// ********************************
	// Wishbone slave
	// ********************************

	// Only a fresh strobe counts; ack_q blocks repeats
	assign req = CYC_I && STB_I && !ack_q;
	// Registers live in the low byte lane
	assign wr = req && WE_I && SEL_I[0];

	// Answer every access in the next cycle
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req;
		end
	end

	// Read mux; reserved bits and unmapped addresses read zero
	always_comb begin
		rdat_d = RST_BYTE;
		if (hit(ADR_I, IDX_ACT_STAT)) begin
			rdat_d = {7'h00, act_q};
		end else if (hit(ADR_I, IDX_SOP_STAT)) begin
			rdat_d = {3'h0, sop_q};
		end else if (hit(ADR_I, IDX_TX_EN)) begin
			rdat_d = tx_en_q;
		end else if (hit(ADR_I, IDX_RX_EN)) begin
			rdat_d = rx_en_q;
		end else if (hit(ADR_I, IDX_RXF_EN)) begin
			rdat_d = rxf_en_q;
		end else if (hit(ADR_I, IDX_PM_EN)) begin
			rdat_d = pm_en_q;
		end else if (hit(ADR_I, IDX_SOP_EN)) begin
			rdat_d = {3'h0, sop_en_q};
		end
	end

	// Capture read data with the answer
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rdat_q <= RST_WORD;
		end else if (req && !WE_I) begin
			rdat_q <= {24'h000000, rdat_d};
		end
	end

	// ********************************
	// Enable registers
	// ********************************

	// Plain read/write masks, reserved bits forced low
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			tx_en_q <= RST_BYTE;
			rx_en_q <= RST_BYTE;
			rxf_en_q <= RST_BYTE;
			pm_en_q <= RST_BYTE;
			sop_en_q <= RST_SOP;
		end else if (wr) begin
			if (hit(ADR_I, IDX_TX_EN)) begin
				tx_en_q <= DAT_I[7:0] & MASK_TX;
			end else if (hit(ADR_I, IDX_RX_EN)) begin
				rx_en_q <= DAT_I[7:0] & MASK_RX;
			end else if (hit(ADR_I, IDX_RXF_EN)) begin
				rxf_en_q <= DAT_I[7:0] & MASK_RXF;
			end else if (hit(ADR_I, IDX_PM_EN)) begin
				pm_en_q <= DAT_I[7:0] & MASK_PM;
			end else if (hit(ADR_I, IDX_SOP_EN)) begin
				sop_en_q <= DAT_I[4:0] & MASK_SOP[4:0];
			end
		end
	end

	// ********************************
	// Frame start flags
	// ********************************

	// One flag per type; detection ignores receive control setup
	// A detect in the clearing cycle wins over the clear
	generate
		for (genvar i = 0; i < SOP_NUM; i++) begin : g_sop
			always_ff @(posedge MCLK or posedge SYS_RST) begin
				if (SYS_RST) begin
					sop_q[i] <= 1'b0;
				end else if (SOP_DETECT[i]) begin
					sop_q[i] <= 1'b1;
				end else if (wr && hit(ADR_I, IDX_SOP_STAT) && DAT_I[i]) begin
					sop_q[i] <= 1'b0;
				end
			end
		end
	endgenerate

	// ********************************
	// Activity wake detection
	// ********************************

	// Two stage sync of the receive line pin
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rx_s1_q <= 1'b0;
			rx_s2_q <= 1'b0;
			rx_s3_q <= 1'b0;
		end else begin
			rx_s1_q <= RX_LINE;
			rx_s2_q <= rx_s1_q;
			rx_s3_q <= rx_s2_q;
		end
	end

	// Edge only from the second stage on
	assign rx_rise = rx_s2_q && !rx_s3_q;

	// Flag blocked entirely while its enable is clear
	// Sync adds two cycles; it is why the clock must be running
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			act_q <= 1'b0;
		end else if (rx_rise && pm_en_q[PM_ACT_BIT]) begin
			act_q <= 1'b1;
		end else if (wr && hit(ADR_I, IDX_ACT_STAT) && DAT_I[0]) begin
			act_q <= 1'b0;
		end
	end

	// ********************************
	// Clock requests
	// ********************************

	// Wake request spans activity start until squelch takes over
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			wake_q <= 1'b0;
		end else if (SQUELCH_ACTIVE || !pm_en_q[PM_WAKE_BIT]) begin
			wake_q <= 1'b0;
		end else if (rx_rise) begin
			wake_q <= 1'b1;
		end
	end

	// Stop request and clock needed; software sleeps otherwise
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			stop_q <= 1'b0;
			need_q <= 1'b0;
		end else begin
			stop_q <= pm_en_q[PM_STOP_BIT] && MAC_IDLE;
			need_q <= SQUELCH_ACTIVE || !MAC_IDLE;
		end
	end

	// ********************************
	// Interrupt outputs
	// ********************************

	// Level outputs, each an OR of enabled flags
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			tx_irq_q <= 1'b0;
			rx_irq_q <= 1'b0;
			rxf_irq_q <= 1'b0;
			pm_irq_q <= 1'b0;
			sop_irq_q <= 1'b0;
		end else begin
			tx_irq_q <= |(TX_STATUS & tx_en_q);
			rx_irq_q <= |(RX_STATUS & rx_en_q);
			rxf_irq_q <= |(RX_FAULT_STATUS & rxf_en_q);
			pm_irq_q <= act_q && pm_en_q[PM_ACT_BIT];
			sop_irq_q <= |(sop_q & sop_en_q);
		end
	end

	// Every output straight from a flip-flop
	assign DAT_O = rdat_q;
	assign ACK_O = ack_q;
	assign TX_IRQ = tx_irq_q;
	assign RX_IRQ = rx_irq_q;
	assign RX_FAULT_IRQ = rxf_irq_q;
	assign PM_IRQ = pm_irq_q;
	assign SOP_IRQ = sop_irq_q;
	assign CLK_STOP_REQ = stop_q;
	assign CLK_START_REQ = wake_q;
	assign CLK_NEEDED = need_q;

	// ********************************
	// Assertions
	// ********************************

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (SYS_RST);

	// Detect shows in the flags next cycle
	a_sop_flag_set: assert property ((SOP_DETECT != 5'h00) |=> ((sop_q & $past(SOP_DETECT)) == $past(SOP_DETECT)))
		else $error("frame start flag not set");

	// Writing zeros never clears a flag
	a_sop_zero_keep: assert property ((wr && hit(ADR_I, IDX_SOP_STAT) && DAT_I[4:0] == 5'h00)
		|=> (($past(sop_q) & ~sop_q) == 5'h00))
		else $error("flag lost on zero write");

	// Write one clears unless a detect comes too
	a_sop_clear: assert property ((wr && hit(ADR_I, IDX_SOP_STAT) && DAT_I[0] && !SOP_DETECT[0])
		|=> !sop_q[0])
		else $error("flag not cleared by one");

	// Frame start output follows enabled flags
	a_sop_irq_gate: assert property (##1 (SOP_IRQ == $past(|(sop_q & sop_en_q))))
		else $error("frame start irq mismatch");

	// Reserved flag bits read zero
	a_read_reserved: assert property (ACK_O && !$past(WE_I) |-> (DAT_O[31:5] == 27'h0 ||
		!$past(hit(ADR_I, IDX_SOP_STAT))))
		else $error("reserved bits read nonzero");

	// Transmit group output tracks status and mask
	a_tx_irq_level: assert property (##1 (TX_IRQ == $past(|(TX_STATUS & tx_en_q))))
		else $error("transmit irq mismatch");

	// Wake flag stays clear while disabled
	a_act_blocked: assert property (!pm_en_q[PM_ACT_BIT] && !act_q |=> !act_q)
		else $error("wake flag set while disabled");

	// Stop request follows enable and idle
	a_stop_request: assert property (##1 (CLK_STOP_REQ == $past(pm_en_q[PM_STOP_BIT] && MAC_IDLE)))
		else $error("clock stop request wrong");

	// Idle and quiet line means no clock needed
	a_idle_no_need: assert property (MAC_IDLE && !SQUELCH_ACTIVE |=> !CLK_NEEDED)
		else $error("clock needed while idle");

	// Squelch forces need, and ends the wake request
	a_squelch_need: assert property (SQUELCH_ACTIVE |=> CLK_NEEDED && !CLK_START_REQ)
		else $error("squelch did not claim clock");

	// Pin activity reaches the start request in three cycles
	sequence s_line_start;
		!rx_s2_q ##1 rx_s2_q;
	endsequence
	a_wake_start: assert property (s_line_start ##0 (pm_en_q[PM_WAKE_BIT] && !SQUELCH_ACTIVE) |=> CLK_START_REQ)
		else $error("no clock start request");

	// Bus answer is a single cycle pulse
	a_ack_single: assert property (ACK_O |=> !ACK_O)
		else $error("ack held too long");

	// Write one clears every selected flag when no detect competes
	// Checks all five lanes, not only the first
	a_clear_lands: assert property ((wr && hit(ADR_I, IDX_SOP_STAT) && SOP_DETECT == 5'h00)
		|=> ((sop_q & $past(DAT_I[4:0])) == 5'h00))
		else $error("flag not cleared by write");

	// Reserved enable bits never hold a one
	// Software may write ones there; the masks must drop them
	a_en_reserved: assert property (!rx_en_q[4] && rxf_en_q[6:4] == 3'h0
		&& pm_en_q[7:4] == 4'h0 && !pm_en_q[1])
		else $error("reserved enable bit set");

	// Enabled line activity sets the wake flag on the next edge
	a_act_set: assert property (rx_rise && pm_en_q[PM_ACT_BIT] |=> act_q)
		else $error("wake flag missed activity");

	// Wake enable clear means no start request
	a_wake_off: assert property (!pm_en_q[PM_WAKE_BIT] |=> !CLK_START_REQ)
		else $error("start request while wake disabled");

	// A busy MAC always claims the clock
	a_need_busy: assert property (!MAC_IDLE |=> CLK_NEEDED)
		else $error("clock not claimed while busy");

	// Stop enable clear means no stop request; software sleeps the part
	a_stop_off: assert property (!pm_en_q[PM_STOP_BIT] |=> !CLK_STOP_REQ)
		else $error("stop request while stop disabled");

	// Receive group output tracks status and mask
	a_rx_irq_level: assert property (##1 (RX_IRQ == $past(|(RX_STATUS & rx_en_q))))
		else $error("receive irq mismatch");

	// Fault group uses the same one cycle gating
	a_fault_irq_level: assert property (##1 (RX_FAULT_IRQ == $past(|(RX_FAULT_STATUS & rxf_en_q))))
		else $error("receive fault irq mismatch");

endmodule // pd_irq_ctrl

// >>> pd_irq_pkg.sv
// Constants for the PD MAC interrupt enable and clock request block
package pd_irq_pkg;
	// Register indices; the byte address is four times the index
	localparam logic [13:0] IDX_ACT_STAT = 14'h1a84;
	localparam logic [13:0] IDX_SOP_STAT = 14'h1a85;
	localparam logic [13:0] IDX_TX_EN = 14'h1a86;
	localparam logic [13:0] IDX_RX_EN = 14'h1a87;
	localparam logic [13:0] IDX_RXF_EN = 14'h1a88;
	localparam logic [13:0] IDX_PM_EN = 14'h1a89;
	localparam logic [13:0] IDX_SOP_EN = 14'h1a8a;
	// Writable or readable bits per register
	localparam logic [7:0] MASK_ACT = 8'h01;
	localparam logic [7:0] MASK_SOP = 8'h1f;
	localparam logic [7:0] MASK_TX = 8'hff;
	localparam logic [7:0] MASK_RX = 8'hef;
	localparam logic [7:0] MASK_RXF = 8'h8f;
	localparam logic [7:0] MASK_PM = 8'h0d;
	// Values after reset
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [4:0] RST_SOP = 5'h00;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	// Control bit positions in the power event register
	localparam int unsigned PM_STOP_BIT = 3;
	localparam int unsigned PM_WAKE_BIT = 2;
	localparam int unsigned PM_ACT_BIT = 0;
	// Number of frame start types
	localparam int unsigned SOP_NUM = 5;
endpackage

// >>> tb_top.sv
// Self-checking bench for the interrupt gating and clock request block
`timescale 1ns/1ps
module tb_top;
	import pd_irq_pkg::*;
	logic mclk = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0, mac_idle = 0, squelch = 0, rx_line = 0;
	logic sw_sleep = 0;
	logic [15:0] adr = 0;
	logic [3:0] sel = 4'hf;
	logic [31:0] dat_i = 0, dat_o, rd;
	logic [4:0] sop = 0;
	logic [7:0] txs = 0, rxs = 0, rfs = 0, v;
	logic ack, tx_irq, rx_irq, rf_irq, pm_irq, sop_irq, stop_req, start_req, clk_need, clk_on;
	int err_count = 0, comparisons = 0, cyc_n = 0, i, k;
	// Model registers, index 0 is the activity status
	logic [7:0] mdl [7];
	logic [7:0] msk [7] = '{MASK_ACT, MASK_SOP, MASK_TX, MASK_RX, MASK_RXF, MASK_PM, MASK_SOP};
	pd_irq_ctrl uut (.MCLK(mclk), .SYS_RST(sys_rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
		.SEL_I(sel), .DAT_I(dat_i), .DAT_O(dat_o), .ACK_O(ack), .SOP_DETECT(sop), .TX_STATUS(txs),
		.RX_STATUS(rxs), .RX_FAULT_STATUS(rfs), .MAC_IDLE(mac_idle), .SQUELCH_ACTIVE(squelch),
		.RX_LINE(rx_line), .TX_IRQ(tx_irq), .RX_IRQ(rx_irq), .RX_FAULT_IRQ(rf_irq), .PM_IRQ(pm_irq),
		.SOP_IRQ(sop_irq), .CLK_STOP_REQ(stop_req), .CLK_START_REQ(start_req), .CLK_NEEDED(clk_need));
	clk_ctl_model ctl (.clk(mclk), .rst(sys_rst), .stop_req(stop_req), .start_req(start_req), .sw_sleep(sw_sleep),
		.clk_on(clk_on));
	// *************
	// Clock, timeout
	// *************
	initial forever #12.5 mclk = ~mclk;
	// Generous ceiling; the sequence needs well under a thousand cycles
	always @(posedge mclk) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 20000) begin
			err_count++;
			report_and_stop;
		end
	end
	// *************
	// Helper tasks
	// *************
	task automatic report_and_stop;
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	// One classic cycle; request held until ack is seen at an edge
	task automatic wb(input logic w, input int idx, input logic [7:0] d);
		@(posedge mclk);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= {IDX_ACT_STAT + idx[13:0], 2'b00};
		dat_i <= {24'h0, d};
		do @(posedge mclk); while (ack !== 1'b1);
		rd = dat_o;
		cyc <= 0;
		stb <= 0;
		// Status registers clear on ones, the rest keep the writable bits
		if (w && idx < 2) mdl[idx] = mdl[idx] & ~d;
		else if (w && idx < 7) mdl[idx] = d & msk[idx];
	endtask
	task automatic rdchk(input int idx);
		wb(0, idx, 0);
		chk(rd, idx < 7 ? {24'h0, mdl[idx]} : 32'h0);
	endtask
	// Let registered inputs and outputs settle, then compare the interrupt, stop request and clock needed outputs
	task automatic outs;
		repeat (5) @(posedge mclk);
		chk(tx_irq, |(txs & mdl[2]));
		chk(rx_irq, |(rxs & mdl[3]));
		chk(rf_irq, |(rfs & mdl[4]));
		chk(sop_irq, |(mdl[1] & mdl[6]));
		chk(pm_irq, mdl[0][0] & mdl[5][0]);
		chk(stop_req, mdl[5][3] & mac_idle);
		chk(clk_need, squelch | !mac_idle);
	endtask
	task automatic pulse(input logic [4:0] p);
		@(posedge mclk);
		sop <= p;
		@(posedge mclk);
		sop <= 0;
		mdl[1] = mdl[1] | {3'h0, p};
		outs;
	endtask
	// ***************
	// Main sequence
	// ***************
	initial begin
		void'($urandom(32'h9405f54a));
		for (i = 0; i < 7; i++) mdl[i] = 0;
		repeat (3) @(posedge mclk);
		sys_rst <= 0;
		for (i = 0; i < 8; i++) rdchk(i);
		outs;
		// Random writes show the bit maps and reserved bits
		for (k = 0; k < 4; k++) begin
			for (i = 2; i < 7; i++) begin
				wb(1, i, 8'($urandom));
				rdchk(i);
			end
		end
		wb(1, 7, 8'hff);
		rdchk(7);
		// Flags record with the mask clear, interrupt stays low
		wb(1, 6, 0);
		pulse(5'($urandom));
		rdchk(1);
		for (i = 0; i < 5; i++) begin
			wb(1, 1, 8'hff);
			wb(1, 6, 8'(1 << i));
			pulse(5'h1f & ~5'(1 << i));
			pulse(5'(1 << i));
		end
		wb(1, 1, 8'h05);
		rdchk(1);
		wb(1, 1, 8'h00);
		rdchk(1);
		// A detect in the clearing cycle keeps every flag
		sop <= 5'h1f;
		wb(1, 1, 8'hff);
		sop <= 0;
		mdl[1] = 8'h1f;
		rdchk(1);
		outs;
		repeat (8) begin
			txs <= 8'($urandom);
			rxs <= 8'($urandom);
			rfs <= 8'($urandom);
			mac_idle <= 1'($urandom);
			squelch <= 1'($urandom);
			wb(1, 2 + $urandom % 4, 8'($urandom));
			outs;
		end
		// Line activity with the wake interrupt disabled sets nothing
		squelch <= 0;
		mac_idle <= 1;
		wb(1, 5, 8'h00);
		rx_line <= 1;
		outs;
		rdchk(0);
		// Stop disabled: no request, so software puts the clock to sleep
		sw_sleep <= 1;
		@(posedge mclk);
		sw_sleep <= 0;
		@(posedge mclk);
		chk(clk_on, 0);
		rx_line <= 0;
		// Wake interrupt armed together with wake request and clock stop
		wb(1, 5, 8'h0d);
		rx_line <= 1;
		mdl[0] = 8'h01;
		outs;
		rdchk(0);
		chk(start_req, 1);
		chk(clk_on, 1);
		squelch <= 1;
		mac_idle <= 0;
		outs;
		chk(start_req, 0);
		chk(clk_on, 1);
		wb(1, 0, 8'h01);
		outs;
		rdchk(0);
		report_and_stop;
	end
endmodule // tb_top
